// ===== common/rtce_pkg.sv
// shared constants and types for the serial access block of the clock/eeprom device
// Functional notes
// - up to 63 more array, 7 more register bytes
// - ack each write byte, then advance address
// - write address wraps within 64/8 byte page
// - surplus bytes overwrite earlier wrapped locations
// - stop starts write cycle, bus ignored meanwhile
// - stop mid-byte or before data: no write
// - no slave address ack while write busy
// - counter holds last read address plus one
// - sixteen-bit counter clears to zero at reset
// - read address acked, eight bits shifted out
// - random read: dummy write then read
// - stop after word address loads counter only
// - master ack requests next sequential byte
// - read counter wraps over whole address space
// - top nibble 1010 array, 1101 registers
// - device select bits must equal 111
// - last address bit: one read, zero write
// - ack address only on 1010111 or 1101111
// - write address byte followed by two word bytes
// - no data ack while write enable latch clear
// - protected write acked, no write cycle
package rtce_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [3:0] ID_ARRAY = 4'ha;
  localparam logic [3:0] ID_REGS = 4'hd;
  localparam logic [2:0] DEV_SEL = 3'h7;
  localparam int ARRAY_PAGE = 64;
  localparam int REGS_PAGE = 8;
  localparam logic [ADDR_W-1:0] ARRAY_MASK = 16'h003f;
  localparam logic [ADDR_W-1:0] REGS_MASK = 16'h0007;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_NS = 50;
  localparam longint T_NVWRITE_NS = 5000000;
  localparam int NVWRITE_CYCLES = int'(T_NVWRITE_NS / CLK_PERIOD_NS);
  typedef struct packed {
    logic regs;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } rtce_wr_s;
  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX, ST_BUSY} rtce_state_e;
  typedef enum logic [1:0] {BY_SLAVE, BY_WAHI, BY_WALO, BY_DATA} rtce_byte_e;
endpackage

// ===== core/rtce_serial_access.sv
// two-wire slave access logic with page write buffer and write fifo
`timescale 1ns/1ns
`default_nettype none

module rtce_fifo #(
  parameter int W = 25,
  parameter int DEPTH = 8
) (
  // clock, reset and enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [PW:0] wr_ptr_r;
  logic [PW:0] rd_ptr_r;
  wire full = (wr_ptr_r[PW] != rd_ptr_r[PW]) && (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]);
  wire empty = (wr_ptr_r == rd_ptr_r);
  wire push = in_valid_in && !full;
  wire pop = out_ready_in && !empty;
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem_r[rd_ptr_r[PW-1:0]];
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else if (en_in) begin
      if (push) begin
        mem_r[wr_ptr_r[PW-1:0]] <= in_data_in;
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule

module rtce_serial_access #(
  parameter int NVWRITE_CYCLES = rtce_pkg::NVWRITE_CYCLES,
  parameter int FIFO_DEPTH = rtce_pkg::FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // two-wire pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  // device state
  input wire logic write_enable_latch_in,
  input wire logic block_protect_in,
  output logic busy_out,
  // read port
  output logic [rtce_pkg::ADDR_W-1:0] rd_addr_out,
  output logic rd_regs_out,
  input wire logic [rtce_pkg::DATA_W-1:0] rd_data_in,
  // nonvolatile write stream
  output logic wr_valid_out,
  input wire logic wr_ready_in,
  output rtce_pkg::rtce_wr_s wr_data_out
);
  function automatic logic id_match(input logic [6:0] sa);
    return (sa[6:3] == rtce_pkg::ID_ARRAY || sa[6:3] == rtce_pkg::ID_REGS) && sa[2:0] == rtce_pkg::DEV_SEL;
  endfunction

  function automatic logic [rtce_pkg::ADDR_W-1:0] page_inc(input logic [rtce_pkg::ADDR_W-1:0] a, input logic regs);
    logic [rtce_pkg::ADDR_W-1:0] m;
    m = regs ? rtce_pkg::REGS_MASK : rtce_pkg::ARRAY_MASK;
    return (a & ~m) | ((a + 16'h0001) & m);
  endfunction

  // pin synchronisers and filtered levels
  logic [2:0] scl_q_r;
  logic [2:0] sda_q_r;
  logic scl_f_r;
  logic sda_f_r;
  wire scl_new = (scl_q_r[1] == scl_q_r[2]) ? scl_q_r[2] : scl_f_r;
  wire sda_new = (sda_q_r[1] == sda_q_r[2]) ? sda_q_r[2] : sda_f_r;
  wire scl_rise = scl_new && !scl_f_r;
  wire scl_fall = !scl_new && scl_f_r;
  wire start_det = scl_f_r && scl_new && sda_f_r && !sda_new;
  wire stop_det = scl_f_r && scl_new && !sda_f_r && sda_new;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      scl_q_r <= 3'h7;
      sda_q_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end else if (clk_en_in) begin
      scl_q_r <= {scl_q_r[1:0], scl_in};
      sda_q_r <= {sda_q_r[1:0], sda_in};
      scl_f_r <= scl_new;
      sda_f_r <= sda_new;
    end
  end

  // protocol state
  rtce_pkg::rtce_state_e state_r;
  rtce_pkg::rtce_byte_e byte_r;
  logic [3:0] bit_r;
  logic [7:0] shift_r;
  logic ack_ph_r;
  logic ack_want_r;
  logic mack_r;
  logic regs_r;
  logic rd_r;
  logic [7:0] wa_hi_r;
  logic [rtce_pkg::ADDR_W-1:0] addr_r;
  logic [6:0] nbytes_r;
  logic [7:0] pbuf_r [rtce_pkg::ARRAY_PAGE];
  logic [rtce_pkg::ARRAY_PAGE-1:0] pvalid_r;
  logic [6:0] drain_r;
  logic [31:0] timer_r;
  logic sda_oe_n_r;

  wire [7:0] rx_byte = {shift_r[6:0], sda_new};
  wire rx_bit = (state_r == rtce_pkg::ST_RX) && !ack_ph_r && scl_rise;
  wire rx_done = rx_bit && (bit_r == rtce_pkg::BIT_LAST);
  wire ack_open = scl_fall && !ack_ph_r && (bit_r == rtce_pkg::BIT_ACK);
  wire ack_close = scl_fall && ack_ph_r;
  wire data_take = rx_done && (byte_r == rtce_pkg::BY_DATA) && write_enable_latch_in;
  wire [5:0] pofs = regs_r ? {3'h0, addr_r[2:0]} : addr_r[5:0];
  wire commit_go = stop_det && (state_r == rtce_pkg::ST_RX) && (byte_r == rtce_pkg::BY_DATA)
                   && (bit_r <= 4'h1) && !ack_ph_r && (nbytes_r != 7'h00) && !block_protect_in;
  wire tx_end = (state_r == rtce_pkg::ST_TX) && !ack_ph_r && scl_fall && (bit_r == rtce_pkg::BIT_LAST);
  wire [6:0] drain_lim = regs_r ? 7'(rtce_pkg::REGS_PAGE) : 7'(rtce_pkg::ARRAY_PAGE);
  wire drain_active = (state_r == rtce_pkg::ST_BUSY) && (drain_r < drain_lim);
  wire [5:0] didx = drain_r[5:0];
  wire fifo_in_ready;
  wire fifo_in_valid = drain_active && pvalid_r[didx];
  wire drain_step = drain_active && (!pvalid_r[didx] || fifo_in_ready);
  rtce_pkg::rtce_wr_s fifo_in_data;
  assign fifo_in_data.regs = regs_r;
  assign fifo_in_data.addr = regs_r ? {addr_r[15:3], didx[2:0]} : {addr_r[15:6], didx};
  assign fifo_in_data.data = pbuf_r[didx];
  wire drive_low = ((state_r == rtce_pkg::ST_RX) && ack_ph_r && ack_want_r)
                   || ((state_r == rtce_pkg::ST_TX) && !ack_ph_r && !shift_r[7]);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_r <= rtce_pkg::ST_IDLE;
      byte_r <= rtce_pkg::BY_SLAVE;
      bit_r <= 4'h0;
      shift_r <= 8'hff;
      ack_ph_r <= 1'b0;
      ack_want_r <= 1'b0;
      mack_r <= 1'b0;
      regs_r <= 1'b0;
      rd_r <= 1'b0;
      wa_hi_r <= 8'h00;
      addr_r <= rtce_pkg::ADDR_RESET;
      nbytes_r <= 7'h00;
      pvalid_r <= '0;
      drain_r <= 7'h00;
      timer_r <= 32'h0;
      sda_oe_n_r <= 1'b1;
    end else if (clk_en_in) begin
      sda_oe_n_r <= !drive_low;
      if (state_r == rtce_pkg::ST_BUSY) begin
        // bus ignored until the write cycle is over
        if (drain_active) begin
          if (drain_step) begin
            drain_r <= drain_r + 7'h01;
          end
        end else if (timer_r >= 32'(NVWRITE_CYCLES - 1)) begin
          state_r <= rtce_pkg::ST_IDLE;
          pvalid_r <= '0;
        end else begin
          timer_r <= timer_r + 32'h1;
        end
      end else if (start_det) begin
        state_r <= rtce_pkg::ST_RX;
        byte_r <= rtce_pkg::BY_SLAVE;
        bit_r <= 4'h0;
        ack_ph_r <= 1'b0;
        ack_want_r <= 1'b0;
        nbytes_r <= 7'h00;
        pvalid_r <= '0;
      end else if (stop_det) begin
        // commit only after a whole acked data byte
        if (commit_go) begin
          state_r <= rtce_pkg::ST_BUSY;
          drain_r <= 7'h00;
          timer_r <= 32'h0;
        end else begin
          state_r <= rtce_pkg::ST_IDLE;
        end
        ack_ph_r <= 1'b0;
      end else if (state_r == rtce_pkg::ST_RX) begin
        if (rx_bit) begin
          shift_r <= rx_byte;
          bit_r <= bit_r + 4'h1;
        end
        if (rx_done) begin
          unique case (byte_r)
            rtce_pkg::BY_SLAVE: begin
              ack_want_r <= id_match(rx_byte[7:1]);
              regs_r <= (rx_byte[7:4] == rtce_pkg::ID_REGS);
              rd_r <= rx_byte[0];
            end
            rtce_pkg::BY_WAHI: begin
              ack_want_r <= 1'b1;
              wa_hi_r <= rx_byte;
            end
            rtce_pkg::BY_WALO: begin
              ack_want_r <= 1'b1;
              addr_r <= {wa_hi_r, rx_byte};
            end
            rtce_pkg::BY_DATA: begin
              ack_want_r <= write_enable_latch_in;
              if (write_enable_latch_in) begin
                pbuf_r[pofs] <= rx_byte;
                pvalid_r[pofs] <= 1'b1;
                addr_r <= page_inc(addr_r, regs_r);
              end
            end
          endcase
        end
        if (ack_open) begin
          ack_ph_r <= 1'b1;
          if (!ack_want_r) begin
            state_r <= rtce_pkg::ST_IDLE;
          end
        end
        if (ack_close) begin
          ack_ph_r <= 1'b0;
          ack_want_r <= 1'b0;
          bit_r <= 4'h0;
          unique case (byte_r)
            rtce_pkg::BY_SLAVE: begin
              if (rd_r) begin
                state_r <= rtce_pkg::ST_TX;
                shift_r <= rd_data_in;
              end else begin
                byte_r <= rtce_pkg::BY_WAHI;
              end
            end
            rtce_pkg::BY_WAHI: byte_r <= rtce_pkg::BY_WALO;
            rtce_pkg::BY_WALO: byte_r <= rtce_pkg::BY_DATA;
            rtce_pkg::BY_DATA: nbytes_r <= nbytes_r + 7'h01;
          endcase
        end
      end else if (state_r == rtce_pkg::ST_TX) begin
        if (!ack_ph_r && scl_fall) begin
          if (bit_r == rtce_pkg::BIT_LAST) begin
            ack_ph_r <= 1'b1;
            bit_r <= rtce_pkg::BIT_ACK;
            shift_r <= 8'hff;
            addr_r <= addr_r + 16'h0001;
          end else begin
            shift_r <= {shift_r[6:0], 1'b1};
            bit_r <= bit_r + 4'h1;
          end
        end
        if (ack_ph_r && scl_rise) begin
          mack_r <= !sda_new;
        end
        if (ack_close) begin
          ack_ph_r <= 1'b0;
          bit_r <= 4'h0;
          if (mack_r) begin
            shift_r <= rd_data_in;
          end else begin
            state_r <= rtce_pkg::ST_IDLE;
          end
        end
      end
    end
  end

  // write stream buffer and registered output stage
  wire fifo_out_valid;
  rtce_pkg::rtce_wr_s fifo_out_data;
  logic wr_valid_r;
  rtce_pkg::rtce_wr_s wr_data_r;
  wire stage_load = fifo_out_valid && (!wr_valid_r || wr_ready_in);

  rtce_fifo #(
    .W($bits(rtce_pkg::rtce_wr_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(sys_clk_in),
    .rst_in(rst_in),
    .en_in(clk_en_in),
    .in_valid_in(fifo_in_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fifo_in_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(!wr_valid_r || wr_ready_in),
    .out_data_out(fifo_out_data)
  );

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wr_valid_r <= 1'b0;
      wr_data_r <= '0;
    end else if (clk_en_in) begin
      if (stage_load) begin
        wr_valid_r <= 1'b1;
        wr_data_r <= fifo_out_data;
      end else if (wr_ready_in) begin
        wr_valid_r <= 1'b0;
      end
    end
  end

  logic busy_r;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      busy_r <= 1'b0;
    end else if (clk_en_in) begin
      busy_r <= (state_r == rtce_pkg::ST_BUSY);
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n_out = sda_oe_n_r;
  assign busy_out = busy_r;
  assign rd_addr_out = addr_r;
  assign rd_regs_out = regs_r;
  assign wr_valid_out = wr_valid_r;
  assign wr_data_out = wr_data_r;

  // checks
  default clocking cb @(posedge sys_clk_in iff clk_en_in); endclocking
  default disable iff (rst_in);

  a_busy_no_ack: assert property (state_r == rtce_pkg::ST_BUSY |=> sda_oe_n_out)
    else $error("line driven during write cycle");
  a_slave_match: assert property (byte_r == rtce_pkg::BY_SLAVE && ack_ph_r && ack_want_r
      |-> shift_r[7:1] == {rtce_pkg::ID_ARRAY, rtce_pkg::DEV_SEL} || shift_r[7:1] == {rtce_pkg::ID_REGS, rtce_pkg::DEV_SEL})
    else $error("address acked without match");
  a_ack_drive: assert property (state_r == rtce_pkg::ST_RX && ack_ph_r && ack_want_r ##1 ack_ph_r
      |-> !sda_oe_n_out)
    else $error("ack not driven");
  a_page_wrap: assert property (data_take |=> addr_r == (regs_r ? {$past(addr_r[15:3]), 3'($past(addr_r[2:0]) + 3'h1)}
      : {$past(addr_r[15:6]), 6'($past(addr_r[5:0]) + 6'h01)}))
    else $error("write address not wrapped in page");
  a_read_step: assert property (tx_end |=> addr_r == $past(addr_r) + 16'h0001)
    else $error("read counter not advanced");
  a_commit_start: assert property (commit_go |=> state_r == rtce_pkg::ST_BUSY ##1 busy_out)
    else $error("write cycle not started");
  a_abort_clean: assert property (stop_det && state_r != rtce_pkg::ST_BUSY && !commit_go
      |=> state_r == rtce_pkg::ST_IDLE)
    else $error("aborted write started a cycle");
  a_wel_nack: assert property (rx_done && byte_r == rtce_pkg::BY_DATA && !write_enable_latch_in
      |=> !ack_want_r && $stable(pvalid_r))
    else $error("data acked with latch clear");
  a_reset_addr: assert property ($past(rst_in) |-> addr_r == rtce_pkg::ADDR_RESET)
    else $error("counter not cleared");

  c_commit: cover property (commit_go);
  c_seq_read: cover property (state_r == rtce_pkg::ST_TX && ack_close && mack_r);
  c_set_addr: cover property (stop_det && byte_r == rtce_pkg::BY_DATA && nbytes_r == 7'h00);
endmodule

`default_nettype wire

// ===== tb/rtce_host_model.sv
// two-wire bus master model driving clock and data
`timescale 1ns/1ns
`default_nettype none
module rtce_host_model #(
  parameter int LOW = 12,
  parameter int HIGH = 8
) (
  // system clock
  input wire logic clk_in,
  // bus lines
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_drv_out
);
  initial begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // also a repeated start; waits out the slave's ack hold first
  task automatic start();
    sda_drv_out = 1'b1;
    tick(LOW);
    scl_out = 1'b1;
    tick(HIGH);
    sda_drv_out = 1'b0;
    tick(HIGH);
    scl_out = 1'b0;
    tick(1);
  endtask
  task automatic stop();
    sda_drv_out = 1'b0;
    tick(LOW);
    scl_out = 1'b1;
    tick(HIGH);
    sda_drv_out = 1'b1;
    tick(HIGH);
  endtask
  // data settles in the low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    sda_drv_out = b;
    tick(LOW);
    scl_out = 1'b1;
    tick(HIGH / 2);
    s = sda_in;
    tick(HIGH / 2);
    scl_out = 1'b0;
    tick(1);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = (s === 1'b0);
  endtask
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~mack, s);
  endtask
endmodule
`default_nettype wire

// ===== tb/rtce_serial_access_test.sv
// self-checking bench for the two-wire serial access block
`timescale 1ns/1ns
`default_nettype none
module rtce_serial_access_test;
  logic sys_clk_in, rst_in, clk_en, wr_latch, prot, wr_ready;
  logic scl, sda_drv, sda_line, sda_o, sda_oe_n, busy, rd_regs, wr_valid;
  logic [15:0] rd_addr;
  logic [7:0] rd_data;
  rtce_pkg::rtce_wr_s wr_data;
  rtce_pkg::rtce_wr_s wq[$];
  int n_mismatch = 0;
  int num_checks = 0;

  function automatic logic [7:0] mem(input logic [15:0] a, input logic c);
    return a[7:0] ^ a[15:8] ^ {c, 7'h25};
  endfunction
  assign rd_data = mem(rd_addr, rd_regs);
  // open drain line with pull-up
  assign sda_line = sda_drv & (sda_oe_n | sda_o);

  // write cycle long enough that the first poll lands inside it
  rtce_serial_access #(.NVWRITE_CYCLES(300)) dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
    .write_enable_latch_in(wr_latch), .block_protect_in(prot), .busy_out(busy),
    .rd_addr_out(rd_addr), .rd_regs_out(rd_regs), .rd_data_in(rd_data),
    .wr_valid_out(wr_valid), .wr_ready_in(wr_ready), .wr_data_out(wr_data));
  rtce_host_model host (.clk_in(sys_clk_in), .sda_in(sda_line), .scl_out(scl), .sda_drv_out(sda_drv));

  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) wq.push_back(wr_data);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL time %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr_addr(input logic [7:0] sel, input logic [15:0] a);
    logic k;
    host.start();
    host.wbyte(sel, k);
    chk(k, 1);
    host.wbyte(a[15:8], k);
    chk(k, 1);
    host.wbyte(a[7:0], k);
    chk(k, 1);
  endtask
  task automatic cur_read(input logic [15:0] a, input logic c);
    logic k;
    logic [7:0] d;
    host.start();
    host.wbyte({c ? 4'hd : 4'ha, 4'hf}, k);
    chk(k, 1);
    host.rbyte(1'b0, d);
    host.stop();
    chk(d, mem(a, c));
  endtask

  task automatic t_reset();
    chk(rd_addr, 16'h0000);
    cur_read(16'h0000, 1'b0);
    chk(rd_addr, 16'h0001);
    $display("reset read test done");
  endtask
  // frozen block must ignore a whole transfer and keep its counter
  task automatic t_freeze();
    logic k;
    clk_en = 1'b0;
    host.start();
    host.wbyte(8'haf, k);
    host.stop();
    clk_en = 1'b1;
    host.tick(5);
    chk(k, 0);
    cur_read(16'h0001, 1'b0);
    $display("clock enable test done");
  endtask
  task automatic t_decode();
    logic [7:0] sel [6] = '{8'hae, 8'hde, 8'hac, 8'h9e, 8'hda, 8'hee};
    logic exp [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    logic k;
    for (int i = 0; i < 6; i++) begin
      host.start();
      host.wbyte(sel[i], k);
      host.stop();
      chk(k, exp[i]);
    end
    $display("decode test done");
  endtask
  task automatic t_page();
    logic k;
    wr_latch = 1'b1;
    wr_ready = 1'b0;
    wr_addr(8'hde, 16'h0006);
    for (int i = 0; i < 10; i++) begin
      host.wbyte(8'(8'h30 + i), k);
      chk(k, 1);
    end
    host.stop();
    host.tick(4);
    chk(busy, 1);
    host.start();
    host.wbyte(8'hae, k);
    host.stop();
    chk(k, 0);
    wr_ready = 1'b1;
    for (int i = 0; i < 400 && wq.size() < 8; i++) host.tick(1);
    chk(wq.size(), 8);
    for (int o = 0; o < 8; o++) chk(wq.pop_front(), {8'h01, 13'h0, 3'(o), 8'(8'h32 + o)});
    k = 1'b0;
    for (int i = 0; i < 20 && !k; i++) begin
      host.start();
      host.wbyte(8'hae, k);
      host.stop();
    end
    chk(k, 1);
    $display("page write test done");
  endtask
  task automatic t_abort();
    logic k;
    logic s;
    wr_addr(8'hae, 16'h0100);
    host.wbyte(8'h11, k);
    for (int i = 0; i < 3; i++) host.bit_io(1'b1, s);
    host.stop();
    host.tick(10);
    chk({busy, 8'(wq.size())}, 0);
    wr_addr(8'hae, 16'h0123);
    host.stop();
    chk(rd_addr, 16'h0123);
    cur_read(16'h0123, 1'b0);
    wr_latch = 1'b0;
    wr_addr(8'hae, 16'h0200);
    host.wbyte(8'h55, k);
    host.stop();
    chk(k, 0);
    wr_latch = 1'b1;
    prot = 1'b1;
    wr_addr(8'hae, 16'h0200);
    host.wbyte(8'h55, k);
    host.stop();
    chk(k, 1);
    host.tick(10);
    chk({busy, 8'(wq.size())}, 0);
    prot = 1'b0;
    $display("abort test done");
  endtask
  task automatic t_seq();
    logic k;
    logic [7:0] d;
    wr_addr(8'hae, 16'hfffe);
    host.start();
    host.wbyte(8'haf, k);
    chk(k, 1);
    host.rbyte(1'b1, d);
    chk(d, mem(16'hfffe, 1'b0));
    host.rbyte(1'b1, d);
    chk(d, mem(16'hffff, 1'b0));
    host.rbyte(1'b0, d);
    host.stop();
    chk(d, mem(16'h0000, 1'b0));
    chk(rd_addr, 16'h0001);
    wr_addr(8'hde, 16'h0005);
    cur_read(16'h0005, 1'b1);
    $display("sequential read test done");
  endtask

  initial begin
    rst_in = 1'b1;
    clk_en = 1'b1;
    wr_latch = 1'b0;
    prot = 1'b0;
    wr_ready = 1'b1;
    repeat (5) @(negedge sys_clk_in);
    rst_in = 1'b0;
    host.tick(5);
    t_reset();
    t_freeze();
    t_decode();
    t_page();
    t_abort();
    t_seq();
    conclude();
  end
  initial begin
    repeat (60000) @(posedge sys_clk_in);
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
